// ---- inc/lsc_pkg.sv ----
// Package for the LED sink serial control block: constants, register map and carrier types.
package lsc_pkg;

   // ==========================================================================
   // Geometry
   // ==========================================================================
   localparam int unsigned CHANNELS  = 16;
   localparam int unsigned DC_BITS   = 7;
   localparam int unsigned DC_LEN    = CHANNELS * DC_BITS;   // 112-bit packet
   localparam int unsigned ONOFF_LEN = CHANNELS;             // 16-bit packet

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned CHAN_DELAY_NS  = 20;
   localparam int unsigned CHAN_DELAY_CYC = (CHAN_DELAY_NS / CLK_PERIOD_NS < 1) ? 1
                                            : CHAN_DELAY_NS / CLK_PERIOD_NS;
   localparam int unsigned HIST_DEPTH     = (CHANNELS - 1) * CHAN_DELAY_CYC;
   localparam int unsigned LOD_SAMPLE_US  = 1;
   localparam int unsigned LOD_SAMPLE_CYC = (LOD_SAMPLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOD_CNT_W      = 8;

   // ==========================================================================
   // Register map (byte addresses)
   // ==========================================================================
   localparam logic [7:0] REG_STATUS   = 8'h00;
   localparam logic [7:0] REG_MASK     = 8'h04;
   localparam logic [7:0] REG_ONOFF    = 8'h08;
   localparam logic [7:0] REG_OPEN_LED = 8'h0C;
   localparam logic [7:0] REG_DC_SEL   = 8'h10;
   localparam logic [7:0] REG_DC_VAL   = 8'h14;
   localparam logic [7:0] REG_PINS     = 8'h18;

   // Status and mask bit positions.
   localparam int unsigned EV_ONOFF_LATCH = 0;
   localparam int unsigned EV_DC_LATCH    = 1;
   localparam int unsigned EV_THERMAL     = 2;
   localparam int unsigned EV_OPEN_LED    = 3;
   localparam int unsigned EV_W           = 4;

   localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
   localparam logic [1:0]      RESP_OKAY   = 2'h0;
   localparam logic [1:0]      RESP_SLVERR = 2'h2;

   // ==========================================================================
   // Carrier types
   // ==========================================================================
   typedef struct packed {
      logic sclk;
      logic sdi;
      logic latch;
      logic mode;
      logic blank;
      logic thermal;
   } lsc_pins_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
   } lsc_addr_t;

endpackage

// ---- design/lsc_top.sv ----
// LED sink serial control: serial shift path, latches, staggered outputs, fault reporting, AXI4-Lite view.
// ============================================================================
// Overview of operation
// - sixteen 7-bit dot-correction values, code scales current.
// - dot-correction packet is 112 bits, MSB first.
// - mode high selects the 112-bit shift path.
// - latch rise in mode high loads dot correction.
// - blank high forces every output off.
// - on/off packet is 16 bits, MSB first.
// - latch rise in mode low loads on/off bits.
// - latch fall in mode low reloads shifter with open-LED status.
// - each channel lags its index times 20 ns.
// - delayed channels keep blank-low duration exactly.
// - serial clock rising edge shifts serial input in.
// - serial output carries bits leaving the shifter.
// - error output pulls low on thermal or open-LED.
// - thermal flag pulls error low regardless of blank.
// - open-LED trips 1 us after turn-on, blank low.
// - blank high masks open-LED on error output.
// - per-channel open-LED status readable through serial output.
// - mode routes serial pins to on/off or dot-correction.
`timescale 1ns/1ps
`default_nettype none

module lsc_top
   import lsc_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  sclk,
   input  wire logic                  serial_in,
   input  wire logic                  latch_strobe,
   input  wire logic                  mode_sel,
   input  wire logic                  blank,
   input  wire logic                  thermal_hot,
   input  wire logic [CHANNELS-1:0]   out_low_volt,
   output logic                       serial_out,
   output logic                       error_n_o,
   output logic                       error_n_oe,
   output logic [CHANNELS-1:0]        chan_on,
   output logic [DC_LEN-1:0]          dot_corr_value,
   output logic                       irq,
   input  wire logic [31:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [31:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // =========================================================================
   // Pin synchronisers
   // =========================================================================
   // The first stage is read only by the second; edges use stages two and three.
   lsc_pins_t            pin_raw;
   lsc_pins_t            meta_q;
   lsc_pins_t            sync_q;
   lsc_pins_t            last_q;
   logic [CHANNELS-1:0]  low_meta_q;
   logic [CHANNELS-1:0]  low_q;

   assign pin_raw = '{sclk: sclk, sdi: serial_in, latch: latch_strobe, mode: mode_sel,
                      blank: blank, thermal: thermal_hot};

   always_ff @(posedge mclk) begin
      meta_q     <= pin_raw;
      sync_q     <= meta_q;
      last_q     <= sync_q;
      low_meta_q <= out_low_volt;
      low_q      <= low_meta_q;
   end

   wire sclk_rise  = sync_q.sclk & ~last_q.sclk;
   wire latch_rise = sync_q.latch & ~last_q.latch;
   wire latch_fall = ~sync_q.latch & last_q.latch;
   wire therm_rise = sync_q.thermal & ~last_q.thermal;

   // =========================================================================
   // Shift path and latches
   // =========================================================================
   // One 112-bit shifter serves both modes; in on/off mode only the low 16
   // bits count, so the tap for the serial output moves with mode.
   logic [DC_LEN-1:0]    shift_q;
   logic [CHANNELS-1:0]  onoff_q;
   logic [DC_LEN-1:0]    dc_q;
   logic [CHANNELS-1:0]  lod_q;

   wire load_lod  = latch_fall & ~sync_q.mode;
   wire load_on   = latch_rise & ~sync_q.mode;
   wire load_dc   = latch_rise & sync_q.mode;
   wire serial_out_tap  = sync_q.mode ? shift_q[DC_LEN-1] : shift_q[ONOFF_LEN-1];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shift_q <= '0;
      end else if (load_lod) begin
         shift_q[ONOFF_LEN-1:0] <= lod_q;
      end else if (sclk_rise) begin
         shift_q <= {shift_q[DC_LEN-2:0], sync_q.sdi};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         onoff_q <= '0;
         dc_q    <= '0;
      end else begin
         if (load_on) begin
            onoff_q <= shift_q[ONOFF_LEN-1:0];
         end
         if (load_dc) begin
            dc_q <= shift_q;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         serial_out     <= 1'b0;
         dot_corr_value <= '0;
      end else begin
         serial_out     <= serial_out_tap;
         dot_corr_value <= dc_q;
      end
   end

   // =========================================================================
   // Blanking and staggered outputs
   // =========================================================================
   // Blank gates before the delay line, so every channel stays lit for exactly
   // the blank-low time, merely shifted by its own lag.
   logic [CHANNELS-1:0]  gated_q;
   logic [CHANNELS-1:0]  hist_q [HIST_DEPTH];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gated_q <= '0;
      end else begin
         gated_q <= onoff_q & {CHANNELS{~sync_q.blank}};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int k = 0; k < HIST_DEPTH; k++) begin
            hist_q[k] <= '0;
         end
      end else begin
         hist_q[0] <= gated_q;
         for (int k = 1; k < HIST_DEPTH; k++) begin
            hist_q[k] <= hist_q[k-1];
         end
      end
   end

   // =========================================================================
   // Per-channel output and open-LED detection
   // =========================================================================
   logic [CHANNELS-1:0]  lod_trip;
   logic [CHANNELS-1:0]  lod_sample;
   logic [CHANNELS-1:0]  chan_d;

   for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
      logic [LOD_CNT_W-1:0] on_cnt_q;

      assign lod_sample[i] = chan_on[i] && (on_cnt_q == LOD_CNT_W'(LOD_SAMPLE_CYC - 1));

      if (i == 0) begin : g_nodly
         assign chan_d[i] = gated_q[i];
      end else begin : g_dly
         assign chan_d[i] = hist_q[i*CHAN_DELAY_CYC-1][i];
      end

      always_ff @(posedge mclk) begin
         if (!rst_n || !chan_on[i]) begin
            on_cnt_q <= '0;
         end else if (on_cnt_q < LOD_CNT_W'(LOD_SAMPLE_CYC)) begin
            on_cnt_q <= on_cnt_q + LOD_CNT_W'(1);
         end
      end

      assign lod_trip[i] = lod_sample[i] & low_q[i] & ~sync_q.blank;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         chan_on <= '0;
         lod_q   <= '0;
      end else begin
         chan_on <= chan_d;
         lod_q   <= (lod_q & ~lod_sample) | lod_trip;
      end
   end

   // =========================================================================
   // Error output
   // =========================================================================
   // Open drain: the pin is only ever pulled low, never driven high.
   wire err_active = sync_q.thermal | ((|lod_q) & ~sync_q.blank);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         error_n_o  <= 1'b0;
         error_n_oe <= 1'b0;
      end else begin
         error_n_o  <= 1'b0;
         error_n_oe <= err_active;
      end
   end

   // =========================================================================
   // AXI4-Lite slave
   // =========================================================================
   lsc_addr_t            aw_q;
   logic                 w_got_q;
   logic [31:0]          wdata_q;
   logic [EV_W-1:0]      status_q;
   logic [EV_W-1:0]      mask_q;
   logic [3:0]           dc_sel_q;

   wire aw_hs   = s_axi_awvalid & s_axi_awready;
   wire w_hs    = s_axi_wvalid & s_axi_wready;
   wire ar_hs   = s_axi_arvalid & s_axi_arready;
   wire do_wr   = aw_q.valid & w_got_q & ~s_axi_bvalid;
   wire wr_hit  = (aw_q.addr == REG_MASK) | (aw_q.addr == REG_DC_SEL);
   wire [7:0] ra = s_axi_araddr[7:0];
   wire rd_stat = ar_hs & (ra == REG_STATUS);
   wire rd_hit  = (ra == REG_STATUS) | (ra == REG_MASK) | (ra == REG_ONOFF) | (ra == REG_OPEN_LED)
                | (ra == REG_DC_SEL) | (ra == REG_DC_VAL) | (ra == REG_PINS);

   wire [DC_BITS-1:0] dc_pick = dc_q[dc_sel_q*DC_BITS +: DC_BITS];
   wire [31:0] rd_mux =
        (ra == REG_STATUS)   ? {28'h0, status_q} :
        (ra == REG_MASK)     ? {28'h0, mask_q} :
        (ra == REG_ONOFF)    ? {16'h0, onoff_q} :
        (ra == REG_OPEN_LED) ? {16'h0, lod_q} :
        (ra == REG_DC_SEL)   ? {28'h0, dc_sel_q} :
        (ra == REG_DC_VAL)   ? {25'h0, dc_pick} :
        (ra == REG_PINS)     ? {29'h0, sync_q.thermal, sync_q.blank, sync_q.mode} : 32'h0;

   wire [EV_W-1:0] ev_set = {|lod_trip, therm_rise, load_dc, load_on};
   // Hardware events win over the read that clears the register.
   wire [EV_W-1:0] status_d = (rd_stat ? {EV_W{1'b0}} : status_q) | ev_set;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         aw_q          <= '0;
         w_got_q       <= 1'b0;
         wdata_q       <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_q.valid & ~aw_hs & ~s_axi_bvalid & ~do_wr;
         s_axi_wready  <= ~w_got_q & ~w_hs & ~s_axi_bvalid & ~do_wr;
         if (aw_hs) aw_q <= '{valid: 1'b1, addr: s_axi_awaddr[7:0]};
         if (w_hs) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            aw_q         <= '0;
            w_got_q      <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mask_q   <= MASK_RESET;
         dc_sel_q <= '0;
      end else if (do_wr && s_axi_wstrb[0]) begin
         if (aw_q.addr == REG_MASK)   mask_q   <= wdata_q[EV_W-1:0];
         if (aw_q.addr == REG_DC_SEL) dc_sel_q <= wdata_q[3:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_hs;
         if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status_q <= '0;
         irq      <= 1'b0;
      end else begin
         status_q <= status_d;
         irq      <= |(status_d & mask_q);
      end
   end

   // =========================================================================
   // Assertions
   // =========================================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   logic [5:0] blank_cnt_q;
   always_ff @(posedge mclk) begin
      if (!rst_n || !sync_q.blank) blank_cnt_q <= '0;
      else if (blank_cnt_q != 6'h3F) blank_cnt_q <= blank_cnt_q + 6'h01;
   end

   AST_BLANK_OFF: assert property (blank_cnt_q > 6'h21 |-> chan_on == '0)
      else $error("Outputs still on after long blank.");
   AST_ONOFF_LATCH: assert property (load_on |=> onoff_q == $past(shift_q[ONOFF_LEN-1:0]))
      else $error("On/off latch did not take shifter.");
   AST_DC_LATCH: assert property (load_dc |=> dc_q == $past(shift_q))
      else $error("Dot-correction latch did not take shifter.");
   AST_DC_HOLD: assert property (!load_dc |=> $stable(dc_q))
      else $error("Dot correction changed without a latch in mode high.");
   AST_SHIFT_IN: assert property (sclk_rise && !load_lod |=> shift_q[0] == $past(sync_q.sdi))
      else $error("Serial bit not shifted in.");
   AST_LOD_LOAD: assert property (load_lod |=> shift_q[ONOFF_LEN-1:0] == $past(lod_q))
      else $error("Open-LED status not loaded on latch fall.");
   AST_ERR_THERM: assert property (sync_q.thermal |=> error_n_oe && !error_n_o)
      else $error("Thermal fault not pulling error low.");
   AST_ERR_MASK: assert property (!sync_q.thermal && sync_q.blank |=> !error_n_oe)
      else $error("Error driven with blank high and no thermal fault.");
   AST_STAGGER: assert property (chan_on[3] == $past(gated_q[3], 1 + 3*CHAN_DELAY_CYC))
      else $error("Channel 3 lag is wrong.");
   AST_NO_LAG0: assert property (chan_on[0] == $past(gated_q[0]))
      else $error("Channel 0 is delayed.");
   AST_LOD_SAMPLE: assert property ($rose(lod_q[2]) |->
                                    $past(g_chan[2].on_cnt_q) == LOD_CNT_W'(LOD_SAMPLE_CYC - 1))
      else $error("Open-LED flag not raised exactly at the 1 us sample.");

   COV_ONOFF: cover property (load_on ##[1:200] load_lod);
   COV_DC: cover property (load_dc);
   COV_LOD: cover property (|lod_trip);
   COV_IRQ: cover property ($rose(irq));

endmodule

`default_nettype wire

// ---- verif/lsc_ser_ctrl.sv ----
// Behavioural serial controller that loads frames into the LED sink block and collects its readback.
`timescale 1ns/1ps
`default_nettype none

module lsc_ser_ctrl
   import lsc_pkg::*;
(
   input  wire logic               serial_out,
   output logic                    sclk,
   output logic                    serial_in,
   output logic                    latch_strobe,
   output logic                    mode_sel,
   output logic [ONOFF_LEN-1:0]    rx
);
   initial begin
      sclk         = 1'b0;
      serial_in    = 1'b0;
      latch_strobe = 1'b0;
      mode_sel     = 1'b0;
      rx           = '0;
   end

   // The serial clock only runs inside a frame and rests low between frames.
   task automatic send(input logic m, input logic [DC_LEN-1:0] f);
      int n;
      n = m ? DC_LEN : ONOFF_LEN;
      #3 mode_sel = m;
      #200;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in = f[i];
         #62.5;
         rx   = {rx[ONOFF_LEN-2:0], serial_out};
         sclk = 1'b1;
         #62.5;
         sclk = 1'b0;
      end
      // Data is stale now; the inverse level keeps it from passing for a real bit.
      serial_in = ~serial_in;
      #100 latch_strobe = 1'b1;
      #100 latch_strobe = 1'b0;
      // Mode stays put well past the falling latch edge.
      #200;
   endtask
endmodule
`default_nettype wire

// ---- verif/lsc_top_tb_top.sv ----
// Self-checking bench for the LED sink serial control block.
`timescale 1ns/1ps
`default_nettype none

module lsc_top_tb_top
   import lsc_pkg::*;
;
   typedef struct packed {
      logic [ONOFF_LEN-1:0] frame;
      logic                 blank;
      logic [CHANNELS-1:0]  exp_on;
   } lsc_row_t;

   // ===========================================================================
   // Signals
   // ===========================================================================
   localparam lsc_row_t   ROWS [4]     = '{'{16'hA5C3, 1'b0, 16'hA5C3}, '{16'h0001, 1'b1, 16'h0000},
                                           '{16'h8000, 1'b0, 16'h8000}, '{16'hFFFF, 1'b0, 16'hFFFF}};
   localparam logic [7:0] RST_ADDR [4] = '{REG_STATUS, REG_MASK, REG_ONOFF, REG_OPEN_LED};
   logic                 mclk = 1'b0;
   logic                 rst_n, blank, thermal_hot;
   logic [CHANNELS-1:0]  out_low_volt, chan_on, prev_on;
   logic                 sclk, serial_in, latch_strobe, mode_sel, serial_out, error_n_o, error_n_oe, irq;
   logic [DC_LEN-1:0]    dot_corr_value, dc_f;
   logic [31:0]          s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]           s_axi_wstrb;
   logic                 s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]           s_axi_bresp, s_axi_rresp;
   wire logic            err_line;
   int                   fail_count, n_compared, on_cnt [CHANNELS], t_rise [CHANNELS];
   int                   cyc_n = 0;

   // The error line has a pull-up: released means high.
   assign err_line = error_n_oe ? error_n_o : 1'b1;

   lsc_top u_dut (.mclk, .rst_n, .sclk, .serial_in, .latch_strobe, .mode_sel, .blank, .thermal_hot,
      .out_low_volt, .serial_out, .error_n_o, .error_n_oe, .chan_on, .dot_corr_value, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   lsc_ser_ctrl u_ctrl (.serial_out, .sclk, .serial_in, .latch_strobe, .mode_sel, .rx());

   always #5 mclk = ~mclk;

   always @(posedge mclk) begin
      cyc_n   <= cyc_n + 1;
      prev_on <= chan_on;
      for (int i = 0; i < CHANNELS; i++) begin
         if (chan_on[i] === 1'b1 && prev_on[i] === 1'b0) t_rise[i] <= cyc_n;
         if (chan_on[i] === 1'b1) on_cnt[i] <= on_cnt[i] + 1;
      end
   end

   // ===========================================================================
   // Tasks
   // ===========================================================================
   task automatic check(input logic [DC_LEN-1:0] seen, input logic [DC_LEN-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic tick(inout int t);
      @(posedge mclk);
      t++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      int   t;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      t     = 0;
      s_axi_awaddr  <= {24'h0, a};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         tick(t);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do tick(t); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, er);
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int t;
      t = 0;
      s_axi_araddr  <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do tick(t); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do tick(t); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, exp);
      check(s_axi_rresp, er);
      @(posedge mclk);
   endtask

   // ===========================================================================
   // Sequence
   // ===========================================================================
   initial begin
      {rst_n, blank, thermal_hot, out_low_volt} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      wait_cyc(10);
      rst_n <= 1'b1;
      wait_cyc(3);
      check(chan_on, '0);
      check(dot_corr_value, '0);
      check(err_line, 1'b1);
      check(irq, 1'b0);
      foreach (RST_ADDR[i]) rd(RST_ADDR[i], 32'h0, RESP_OKAY);
      foreach (ROWS[i]) begin
         blank <= ROWS[i].blank;
         u_ctrl.send(1'b0, {96'h0, ROWS[i].frame});
         wait_cyc(40);
         check(chan_on, ROWS[i].exp_on);
         rd(REG_ONOFF, {16'h0, ROWS[i].frame}, RESP_OKAY);
      end
      check(dot_corr_value, '0);
      check(irq, 1'b0);
      wr(REG_MASK, 32'h1 << EV_ONOFF_LATCH, RESP_OKAY);
      wait_cyc(2);
      check(irq, 1'b1);
      rd(REG_STATUS, 32'h1 << EV_ONOFF_LATCH, RESP_OKAY);
      rd(REG_STATUS, 32'h0, RESP_OKAY);
      check(irq, 1'b0);
      blank <= 1'b1;
      wait_cyc(40);
      foreach (on_cnt[i]) on_cnt[i] = 0;
      blank <= 1'b0;
      wait_cyc(50);
      blank <= 1'b1;
      wait_cyc(40);
      for (int i = 0; i < CHANNELS; i++) begin
         check(on_cnt[i], 50);
         check(t_rise[i] - t_rise[0], i * CHAN_DELAY_CYC);
      end
      blank <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) dc_f[i*DC_BITS +: DC_BITS] = 7'(127 - i * 8);
      u_ctrl.send(1'b1, dc_f);
      wait_cyc(10);
      check(dot_corr_value, dc_f);
      check(chan_on, 16'hFFFF);
      wr(REG_DC_SEL, 32'h5, RESP_OKAY);
      rd(REG_DC_VAL, {25'h0, dc_f[5*DC_BITS +: DC_BITS]}, RESP_OKAY);
      rd(REG_DC_SEL, 32'h5, RESP_OKAY);
      rd(REG_STATUS, 32'h1 << EV_DC_LATCH, RESP_OKAY);
      blank        <= 1'b1;
      out_low_volt <= 16'h0024;
      wait_cyc(40);
      blank <= 1'b0;
      wait_cyc(LOD_SAMPLE_CYC + 60);
      check(err_line, 1'b0);
      rd(REG_OPEN_LED, 32'h0024, RESP_OKAY);
      blank <= 1'b1;
      wait_cyc(5);
      check(err_line, 1'b1);
      thermal_hot <= 1'b1;
      wait_cyc(5);
      check(err_line, 1'b0);
      rd(REG_PINS, 32'h7, RESP_OKAY);
      thermal_hot <= 1'b0;
      blank       <= 1'b0;
      wait_cyc(5);
      u_ctrl.send(1'b0, {96'h0, 16'hFFFF});
      u_ctrl.send(1'b0, {96'h0, 16'hFFFF});
      check(u_ctrl.rx, 16'h0024);
      @(posedge mclk);
      wr(REG_MASK, 32'hF, RESP_OKAY);
      check(irq, 1'b1);
      rd(REG_STATUS, 32'hD, RESP_OKAY);
      wr(REG_ONOFF, 32'h0, RESP_SLVERR);
      rd(8'h40, 32'h0, RESP_SLVERR);
      rd(REG_ONOFF, 32'hFFFF, RESP_OKAY);
      stop_test();
   end

   // The whole sequence needs well under 60 us; five times that means a hang.
   initial begin
      #300000;
      fail_count++;
      stop_test();
   end
endmodule
`default_nettype wire
